// *** rtl/hcb_pkg.sv ***
// Shared constants for the buffer RAM programmed-I/O port
package hcb_pkg;
  localparam logic [6:0] REG_XFER_BYTE_COUNT = 7'h22;
  localparam logic [6:0] REG_CPU_IRQ_FLAGS   = 7'h24;
  localparam logic [6:0] REG_ACK_LIST_LENGTH = 7'h2b;
  localparam logic [6:0] REG_BUFFER_STATE    = 7'h2c;
  localparam logic [6:0] REG_ISO_BUF_WINDOW  = 7'h40;
  localparam logic [6:0] REG_ACK_BUF_WINDOW  = 7'h41;
  localparam int         CMD_WRITE_BIT       = 7;
  localparam int         IRQ_ACK_SERVICED    = 1;
  localparam int         IRQ_TRANSFER_END    = 2;
  localparam int         ST_ISO0_FULL        = 0;
  localparam int         ST_ISO1_FULL        = 1;
  localparam int         ST_ACK_FULL         = 2;
  localparam int         ST_ISO0_DONE        = 3;
  localparam int         ST_ISO1_DONE        = 4;
  localparam int         ST_ACK_DONE         = 5;
  localparam logic [15:0] RST_WORD           = 16'h0000;
  localparam int         RAM_BYTES           = 4096;
  localparam int         ADDR_W              = 12;
  localparam int         CLK_HZ              = 20000000;
  localparam int         FRAME_US            = 1000;
  localparam int         FRAME_CYCLES        = CLK_HZ / 1000000 * FRAME_US;
  localparam int         SERVICE_CYCLES      = 16;
  typedef enum logic [1:0] {PORT_IDLE, PORT_REG, PORT_ISO, PORT_ACK} hcb_port_e;
endpackage : hcb_pkg

// *** rtl/hcb_skid_buffer.sv ***
// Two-entry valid/ready buffer on the data path
`timescale 1ns/1ps
`default_nettype none
module hcb_skid_buffer #(
  parameter int WIDTH = 17
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wrPtr_q;
  logic             rdPtr_q;
  logic [1:0]       count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != 2'd2);
  assign outValid = (count_q != 2'd0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'd0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wrPtr_q] <= inData;
        wrPtr_q        <= ~wrPtr_q;
      end
      if (pop)
        rdPtr_q <= ~rdPtr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : hcb_skid_buffer
`default_nettype wire

// *** rtl/hcb_buffer_port.sv ***
// Buffer RAM programmed-I/O command/data port
`timescale 1ns/1ps
`default_nettype none
module hcb_buffer_port
  import hcb_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Processor bus, one word per strobe
  input  wire logic        cmdStrobe,
  input  wire logic        dataWrStrobe,
  input  wire logic        dataRdStrobe,
  input  wire logic [15:0] busWrData,
  output logic [15:0]      busRdData,
  output logic             busRdValid,
  output logic             busBusy,
  // Controller state
  input  wire logic        hostRunning,
  // Frame and traffic indications
  output logic             startOfFrame,
  output logic             packetSend,
  output logic             isoCpuHalf
);
  logic [7:0]  ram_q [RAM_BYTES];
  logic [7:0]  cmd_q;
  hcb_port_e   port_q;
  logic [15:0] xferCount_q;
  logic [15:0] ackLen_q;
  logic [15:0] irq_q;
  logic [15:0] status_q;
  logic [15:0] ptr_q;
  logic        isoHalf_q;
  logic [31:0] frameCnt_q;
  logic [7:0]  svcCnt_q;
  logic [15:0] rdData_q;
  logic        rdValid_q;
  logic        sof_q;
  logic        pkt_q;
  logic        fifoValid;
  logic        fifoReady;
  logic [16:0] fifoData;
  logic        inReady;
  logic        dataIsWrite;
  logic        sofNow;
  logic        endNow;
  logic        svcDone;
  logic        bothFull;
  logic [11:0] evenAddr;
  logic [11:0] halfBase;
  logic [11:0] isoLen;

  // Strobes queue so a busy drain never drops a word
  hcb_skid_buffer #(.WIDTH(17)) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (dataWrStrobe || dataRdStrobe),
    .inReady  (inReady),
    .inData   ({dataWrStrobe, busWrData}),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoData)
  );

  assign fifoReady   = !rdValid_q;
  assign dataIsWrite = fifoData[16];
  assign bothFull    = status_q[ST_ISO0_FULL] && status_q[ST_ISO1_FULL];
  assign isoLen      = ackLen_q[11:0] == 12'h000 ? 12'h000 : 12'h800 - ackLen_q[12:1];
  // Halves share one length, so the second base is offset by it
  assign halfBase    = ackLen_q[11:0] + (isoHalf_q ? isoLen : 12'h000);
  assign evenAddr    = (port_q == PORT_ISO) ? halfBase + {ptr_q[11:1], 1'b0}
                                            : {ptr_q[11:1], 1'b0};
  assign sofNow      = (frameCnt_q == 32'(FRAME_LEN - 1));
  assign endNow      = fifoValid && fifoReady && (port_q == PORT_ISO || port_q == PORT_ACK)
                       && (ptr_q + 16'h0002 == xferCount_q);
  assign svcDone     = (svcCnt_q == 8'd1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_q  <= 8'h00;
      port_q <= PORT_IDLE;
    end
    else if (cmdStrobe)
    begin
      cmd_q <= busWrData[7:0];
      if (busWrData[6:0] == REG_ISO_BUF_WINDOW)
        port_q <= PORT_ISO;
      else if (busWrData[6:0] == REG_ACK_BUF_WINDOW)
        port_q <= PORT_ACK;
      else
        port_q <= PORT_REG;
    end
  end

  // Pointer restarts only on a new command, never per word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_q <= RST_WORD;
    else if (cmdStrobe)
      ptr_q <= RST_WORD;
    else if (fifoValid && fifoReady && (port_q == PORT_ISO || port_q == PORT_ACK))
      ptr_q <= ptr_q + 16'h0002;
  end

  always_ff @(posedge clk)
  begin
    if (fifoValid && fifoReady && dataIsWrite
        && (port_q == PORT_ISO || port_q == PORT_ACK))
    begin
      ram_q[evenAddr]         <= fifoData[7:0];
      ram_q[evenAddr + 12'd1] <= fifoData[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xferCount_q <= RST_WORD;
      ackLen_q    <= RST_WORD;
    end
    else if (fifoValid && fifoReady && dataIsWrite && port_q == PORT_REG && cmd_q[CMD_WRITE_BIT])
    begin
      if (cmd_q[6:0] == REG_XFER_BYTE_COUNT)
        xferCount_q <= fifoData[15:0];
      else if (cmd_q[6:0] == REG_ACK_LIST_LENGTH)
        ackLen_q <= fifoData[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_q  <= RST_WORD;
      rdValid_q <= 1'b0;
    end
    else if (rdValid_q)
      rdValid_q <= 1'b0;
    else if (fifoValid && !dataIsWrite)
    begin
      rdValid_q <= 1'b1;
      if (port_q == PORT_ISO || port_q == PORT_ACK)
        rdData_q <= {ram_q[evenAddr + 12'd1], ram_q[evenAddr]};
      else if (cmd_q[6:0] == REG_XFER_BYTE_COUNT)
        rdData_q <= xferCount_q;
      else if (cmd_q[6:0] == REG_CPU_IRQ_FLAGS)
        rdData_q <= irq_q;
      else if (cmd_q[6:0] == REG_ACK_LIST_LENGTH)
        rdData_q <= ackLen_q;
      else if (cmd_q[6:0] == REG_BUFFER_STATE)
        rdData_q <= status_q;
      else
        rdData_q <= RST_WORD;
    end
  end

  // Frame timer and controller service delay
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameCnt_q <= 32'd0;
      sof_q      <= 1'b0;
    end
    else
    begin
      frameCnt_q <= sofNow ? 32'd0 : frameCnt_q + 32'd1;
      sof_q      <= sofNow;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      svcCnt_q <= 8'd0;
    else if (endNow && port_q == PORT_ACK && dataIsWrite && hostRunning)
      svcCnt_q <= 8'(SERVICE_CYCLES);
    else if (svcCnt_q != 8'd0)
      svcCnt_q <= svcCnt_q - 8'd1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pkt_q <= 1'b0;
    else
      pkt_q <= svcDone && hostRunning;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      isoHalf_q <= 1'b0;
    else if (sofNow && bothFull)
      isoHalf_q <= 1'b1;
    else if (sofNow)
      isoHalf_q <= ~isoHalf_q;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= RST_WORD;
    else
    begin
      if (fifoValid && fifoReady && dataIsWrite && port_q == PORT_REG
          && cmd_q[CMD_WRITE_BIT] && cmd_q[6:0] == REG_CPU_IRQ_FLAGS)
        irq_q <= irq_q & ~fifoData[15:0];
      if (endNow)
        irq_q[IRQ_TRANSFER_END] <= 1'b1;
      if (svcDone && hostRunning)
        irq_q[IRQ_ACK_SERVICED] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= RST_WORD;
    else
    begin
      if (fifoValid && fifoReady && !dataIsWrite && port_q == PORT_ISO)
      begin
        status_q[isoHalf_q ? ST_ISO1_FULL : ST_ISO0_FULL] <= 1'b0;
        status_q[isoHalf_q ? ST_ISO1_DONE : ST_ISO0_DONE] <= 1'b0;
      end
      if (endNow && dataIsWrite && port_q == PORT_ACK)
        status_q[ST_ACK_FULL] <= 1'b1;
      if (endNow && dataIsWrite && port_q == PORT_ISO)
        status_q[isoHalf_q ? ST_ISO1_FULL : ST_ISO0_FULL] <= 1'b1;
      if (svcDone && hostRunning)
        status_q[ST_ACK_DONE] <= 1'b1;
    end
  end

  assign busRdData    = rdData_q;
  assign busRdValid   = rdValid_q;
  assign busBusy      = !inReady;
  assign startOfFrame = sof_q;
  assign packetSend   = pkt_q;
  assign isoCpuHalf   = isoHalf_q;

  property p_end_sets_irq;
    @(posedge clk) disable iff (!rst_n) endNow |=> irq_q[IRQ_TRANSFER_END];
  endproperty
  a_end_sets_irq: assert property (p_end_sets_irq) else $error("end flag not set");

  property p_ptr_step;
    @(posedge clk) disable iff (!rst_n)
      (fifoValid && fifoReady && !cmdStrobe && port_q == PORT_ACK) |=> ptr_q == $past(ptr_q) + 16'h0002;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step by two");

  property p_both_full_half1;
    @(posedge clk) disable iff (!rst_n) (sofNow && bothFull) |=> isoHalf_q;
  endproperty
  a_both_full_half1: assert property (p_both_full_half1) else $error("half 1 not chosen");

  property p_swap;
    @(posedge clk) disable iff (!rst_n) (sofNow && !bothFull) |=> isoHalf_q != $past(isoHalf_q);
  endproperty
  a_swap: assert property (p_swap) else $error("halves not swapped");

  property p_no_pkt_idle;
    @(posedge clk) disable iff (!rst_n) !$past(hostRunning) |-> !pkt_q;
  endproperty
  a_no_pkt_idle: assert property (p_no_pkt_idle) else $error("packet while not running");

  property p_ack_full;
    @(posedge clk) disable iff (!rst_n)
      (endNow && dataIsWrite && port_q == PORT_ACK) |=> status_q[ST_ACK_FULL];
  endproperty
  a_ack_full: assert property (p_ack_full) else $error("ack full not set");

  sequence s_service;
    svcDone && hostRunning;
  endsequence
  property p_serviced;
    @(posedge clk) disable iff (!rst_n) s_service |=> irq_q[IRQ_ACK_SERVICED] && status_q[ST_ACK_DONE];
  endproperty
  a_serviced: assert property (p_serviced) else $error("service flags missing");

  property p_cmd_port;
    @(posedge clk) disable iff (!rst_n)
      (cmdStrobe && busWrData[6:0] == REG_ACK_BUF_WINDOW) |=> port_q == PORT_ACK && ptr_q == 16'h0000;
  endproperty
  a_cmd_port: assert property (p_cmd_port) else $error("ack port not selected");
endmodule : hcb_buffer_port
`default_nettype wire

// *** dv/hcb_cpu_model.sv ***
// Processor-side model that drives the command/data bus
`timescale 1ns/1ps
`default_nettype none
module hcb_cpu_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bus toward the port
  output logic             cmdStrobe,
  output logic             dataWrStrobe,
  output logic             dataRdStrobe,
  output logic [15:0]      busWrData,
  input  wire logic [15:0] busRdData,
  input  wire logic        busRdValid,
  input  wire logic        busBusy
);
  initial
  begin
    cmdStrobe    = 1'b0;
    dataWrStrobe = 1'b0;
    dataRdStrobe = 1'b0;
    busWrData    = 16'h0000;
  end
  // Gap first so queued words drain; a command sent over them takes effect at once and they follow it
  task automatic cmd(input logic [7:0] code);
    repeat (6) @(posedge clk);
    cmdStrobe <= 1'b1;
    busWrData <= {8'h00, code};
    @(posedge clk);
    cmdStrobe <= 1'b0;
  endtask : cmd
  // Strobe held; a word is taken at each edge where the port is not busy
  task automatic wr(input logic [15:0] d);
    dataWrStrobe <= 1'b1;
    busWrData    <= d;
    do @(posedge clk); while (busBusy);
  endtask : wr
  task automatic wr_end();
    dataWrStrobe <= 1'b0;
    busWrData    <= ~busWrData;
  endtask : wr_end
  task automatic rd(output logic [15:0] d);
    int n;
    dataRdStrobe <= 1'b1;
    do @(posedge clk); while (busBusy);
    dataRdStrobe <= 1'b0;
    for (n = 0; n < 20 && busRdValid !== 1'b1; n++) @(posedge clk);
    d = busRdData;
  endtask : rd
  task automatic regw(input logic [6:0] idx, input logic [15:0] v);
    cmd({1'b1, idx});
    wr(v);
    wr_end();
  endtask : regw
  task automatic regr(input logic [6:0] idx, output logic [15:0] d);
    cmd({1'b0, idx});
    rd(d);
  endtask : regr
endmodule : hcb_cpu_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the buffer RAM port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hcb_pkg::*;
  localparam int FLEN = 200;
  logic        clk;
  logic        rst_n;
  logic        hostRunning;
  logic        cmdStrobe;
  logic        dataWrStrobe;
  logic        dataRdStrobe;
  logic [15:0] busWrData;
  logic [15:0] busRdData;
  logic        busRdValid;
  logic        busBusy;
  logic        startOfFrame;
  logic        packetSend;
  logic        isoCpuHalf;
  logic [15:0] v;
  int          checks = 0;
  int          failCount = 0;
  int          pkts = 0;

  hcb_buffer_port #(.FRAME_LEN(FLEN)) hcb_buffer_port_i (
    .clk(clk), .rst_n(rst_n), .cmdStrobe(cmdStrobe), .dataWrStrobe(dataWrStrobe),
    .dataRdStrobe(dataRdStrobe), .busWrData(busWrData), .busRdData(busRdData),
    .busRdValid(busRdValid), .busBusy(busBusy), .hostRunning(hostRunning),
    .startOfFrame(startOfFrame), .packetSend(packetSend), .isoCpuHalf(isoCpuHalf));
  hcb_cpu_model hcb_cpu_model_i (
    .clk(clk), .rst_n(rst_n), .cmdStrobe(cmdStrobe), .dataWrStrobe(dataWrStrobe),
    .dataRdStrobe(dataRdStrobe), .busWrData(busWrData), .busRdData(busRdData),
    .busRdValid(busRdValid), .busBusy(busBusy));

  initial
  begin
    clk         = 1'b0;
    rst_n       = 1'b0;
    hostRunning = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    if (packetSend === 1'b1)
      pkts++;

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic do_reset(input logic run);
    rst_n       <= 1'b0;
    hostRunning <= run;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  task automatic wait_sof();
    int n;
    for (n = 0; n < 400 && startOfFrame !== 1'b1; n++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : wait_sof

  task automatic t_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("reset outputs", {12'h000, busRdValid, startOfFrame, packetSend, isoCpuHalf}, 16'h0);
    do_reset(1'b0);
    hcb_cpu_model_i.regr(REG_CPU_IRQ_FLAGS, v);
    check("irq after reset", v, RST_WORD);
    hcb_cpu_model_i.regr(REG_BUFFER_STATE, v);
    check("state after reset", v, RST_WORD);
    $display("t_reset done");
  endtask : t_reset

  // Forty back-to-back words drain one per cycle, so the two-entry queue never fills and busy stays low
  task automatic t_ack(input logic run);
    int i;
    int p0;
    do_reset(run);
    p0 = pkts;
    hcb_cpu_model_i.regw(REG_CPU_IRQ_FLAGS, 16'h0004);
    hcb_cpu_model_i.regw(REG_ACK_LIST_LENGTH, 16'h1000);
    hcb_cpu_model_i.regw(REG_XFER_BYTE_COUNT, 16'h0050);
    hcb_cpu_model_i.cmd(8'hc1);
    for (i = 0; i < 40; i++) hcb_cpu_model_i.wr(16'h0101 * i[15:0]);
    hcb_cpu_model_i.wr_end();
    repeat (40) @(posedge clk);
    hcb_cpu_model_i.regr(REG_CPU_IRQ_FLAGS, v);
    check("irq flags", v, run ? 16'h0006 : 16'h0004);
    hcb_cpu_model_i.regr(REG_BUFFER_STATE, v);
    check("buffer state", v, run ? 16'h0024 : 16'h0004);
    check("packets", 16'(pkts - p0), {15'h0, run});
    $display("t_ack done");
  endtask : t_ack

  task automatic t_ptr();
    int i;
    do_reset(1'b0);
    hcb_cpu_model_i.regw(REG_ACK_LIST_LENGTH, 16'h1000);
    hcb_cpu_model_i.regw(REG_XFER_BYTE_COUNT, 16'h0008);
    hcb_cpu_model_i.cmd(8'hc1);
    for (i = 0; i < 3; i++) hcb_cpu_model_i.wr(16'h5a00 + i[15:0]);
    hcb_cpu_model_i.wr_end();
    hcb_cpu_model_i.regr(REG_CPU_IRQ_FLAGS, v);
    check("no end at six bytes", v, 16'h0000);
    hcb_cpu_model_i.cmd(8'hc1);
    for (i = 0; i < 4; i++) hcb_cpu_model_i.wr(16'h1234 + 16'h1111 * i[15:0]);
    hcb_cpu_model_i.wr_end();
    hcb_cpu_model_i.regr(REG_CPU_IRQ_FLAGS, v);
    check("end at eight bytes", v, 16'h0004);
    hcb_cpu_model_i.cmd(8'h41);
    for (i = 0; i < 4; i++)
    begin
      hcb_cpu_model_i.rd(v);
      check("ack readback", v, 16'h1234 + 16'h1111 * i[15:0]);
    end
    $display("t_ptr done");
  endtask : t_ptr

  task automatic t_iso();
    logic h;
    do_reset(1'b0);
    hcb_cpu_model_i.regw(REG_ACK_LIST_LENGTH, 16'h0800);
    hcb_cpu_model_i.regw(REG_XFER_BYTE_COUNT, 16'h0004);
    wait_sof();
    h = isoCpuHalf;
    wait_sof();
    check("swap empty", {15'h0, isoCpuHalf}, {15'h0, ~h});
    hcb_cpu_model_i.cmd(8'hc0);
    hcb_cpu_model_i.wr(16'hbeef);
    hcb_cpu_model_i.wr(16'hcafe);
    hcb_cpu_model_i.wr_end();
    hcb_cpu_model_i.regr(REG_BUFFER_STATE, v);
    check("one half full", v, 16'h0001 << ~h);
    wait_sof();
    check("swap one full", {15'h0, isoCpuHalf}, {15'h0, h});
    hcb_cpu_model_i.cmd(8'hc0);
    hcb_cpu_model_i.wr(16'h0f0f);
    hcb_cpu_model_i.wr(16'hf0f0);
    hcb_cpu_model_i.wr_end();
    repeat (2)
    begin
      wait_sof();
      check("held at half one", {15'h0, isoCpuHalf}, 16'h0001);
    end
    hcb_cpu_model_i.regr(REG_BUFFER_STATE, v);
    check("both full", v, 16'h0003);
    hcb_cpu_model_i.cmd(8'h40);
    hcb_cpu_model_i.rd(v);
    hcb_cpu_model_i.regr(REG_BUFFER_STATE, v);
    check("read clears half one", v, 16'h0001);
    $display("t_iso done");
  endtask : t_iso

  initial
  begin
    t_reset();
    t_ack(1'b0);
    t_ack(1'b1);
    t_ptr();
    t_iso();
    conclude();
  end
  // Whole run needs under two thousand cycles; this margin only catches a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    failCount++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
